// ### bench/cbs_bus_master.sv
`timescale 1ns/1ps
module cbs_bus_master (
	// Clock.
	input wire core_clk,
	// Address cycle.
	output logic addrCycle,
	output logic [1:0] addrKind,
	output logic addrCsrSpace,
	output logic [31:0] addrValue,
	output logic addrRelease,
	input wire waitOut,
	// Data cycle.
	output logic dcRead,
	output logic dcWrite,
	output logic dcBlock,
	output logic [10:0] dcSecAddr,
	output logic [31:0] dcWriteData,
	input wire dcReady,
	// Read answer.
	input wire ansValid,
	output logic ansReady,
	input wire [31:0] ansData,
	input wire ansTpin,
	input wire [2:0] ansStatus
);
	// Idle bus at time zero.
	initial begin
		{addrCycle, addrKind, addrCsrSpace, addrValue, addrRelease} = '0;
		{dcRead, dcWrite, dcBlock, dcSecAddr, dcWriteData, ansReady} = '0;
	end
	// One primary address cycle; a slave that asks for decode time gets it.
	task automatic addr(input [1:0] kind, input bit csr, input [31:0] v);
		bit held;
		@(negedge core_clk);
		addrKind = kind;
		addrCsrSpace = csr;
		addrValue = v;
		addrCycle = 1;
		@(posedge core_clk);
		held = waitOut;
		@(negedge core_clk);
		addrCycle = 0;
		addrValue = ~v;
		if (held) @(negedge core_clk);
	endtask
	// Raises a read once the slave can take it, or anyway after 100 cycles of waiting.
	task automatic issue(input bit blk, input [10:0] sa);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (!dcReady && n < 100);
		dcBlock = blk;
		dcSecAddr = sa;
		dcRead = 1;
		@(negedge core_clk);
		dcRead = 0;
		dcSecAddr = ~sa;
	endtask
	// Accepts one queued answer; until then the receiver stalls.
	task automatic take(output [31:0] d, output t, output [2:0] s);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (!ansValid && n < 100);
		d = ansData;
		t = ansTpin;
		s = ansStatus;
		ansReady = 1;
		@(negedge core_clk);
		ansReady = 0;
	endtask
	task automatic rd(input bit blk, input [10:0] sa, output [31:0] d, output t, output [2:0] s);
		issue(blk, sa);
		take(d, t, s);
	endtask
	task automatic wr(input [10:0] sa, input [31:0] v);
		@(negedge core_clk);
		dcSecAddr = sa;
		dcWriteData = v;
		dcWrite = 1;
		@(negedge core_clk);
		dcWrite = 0;
		dcWriteData = ~v;
	endtask
	// Releases the primary address so the slave deselects.
	task automatic drop;
		@(negedge core_clk);
		addrRelease = 1;
		@(negedge core_clk);
		addrRelease = 0;
	endtask
endmodule

// ### bench/cbs_event_slave_props.sv
`timescale 1ns/1ps
`include "cbs_defs.vh"
module cbs_event_slave_props (
	// Clock and reset.
	input wire core_clk,
	input wire reset_n,
	input wire masterReset,
	// Address side.
	input wire [4:0] geoAddress,
	input wire addrCycle,
	input wire [1:0] addrKind,
	input wire addrCsrSpace,
	input wire [31:0] addrValue,
	input wire waitOut,
	input wire dataSelected,
	// Answer side.
	input wire ansValid,
	input wire ansReady,
	input wire [31:0] ansData,
	input wire ansTpin,
	// Buffer management.
	input wire cfgWrite,
	input wire loadNextEvent,
	input wire eventDone,
	input wire [31:0] bufferPointerReg,
	input wire [31:0] wordCountReg,
	input wire memTestMode,
	input wire bufferingInProgress,
	input wire bufFull,
	input wire bufEmpty
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	// Pointer fields, named so the pointer relations read plainly.
	wire [2:0] rdPtr = bufferPointerReg[10:8];
	wire [2:0] wrPtr = bufferPointerReg[2:0];
	chk_bcast_wait: assert property (addrCycle && addrKind == `CBS_KIND_BCAST |-> waitOut)
		else $error("wait missing on broadcast");
	chk_geo_select: assert property (addrCycle && addrKind == `CBS_KIND_GEO && !addrCsrSpace
		&& addrValue[4:0] == geoAddress |=> dataSelected) else $error("geographic select missed");
	chk_empty_flag: assert property (bufEmpty == (rdPtr == wrPtr - 3'h1))
		else $error("empty flag wrong");
	chk_full_flag: assert property (bufFull == (wrPtr == rdPtr - 3'h1))
		else $error("full flag wrong");
	chk_bip_full: assert property (bufFull |-> bufferingInProgress)
		else $error("buffering not extended while full");
	chk_master_reset: assert property (masterReset && !cfgWrite && !eventDone |=>
		bufferPointerReg == 32'h00000700 && wordCountReg == 32'h00000000) else $error("master reset pointers");
	chk_write_advance: assert property (eventDone && !bufFull && !masterReset && !cfgWrite |=>
		wrPtr == $past(wrPtr) + 3'h1) else $error("write pointer did not advance");
	chk_read_advance: assert property (loadNextEvent && !masterReset && !cfgWrite |=>
		rdPtr == $past(rdPtr) + 3'h1) else $error("read pointer did not advance");
	chk_count_hidden: assert property (!memTestMode |-> wordCountReg == 32'h00000000)
		else $error("word count visible outside test mode");
	chk_answer_hold: assert property (ansValid && !ansReady |=> ansValid && $stable(ansData))
		else $error("answer dropped during stall");
	cov_scan_tpin: cover property (ansValid && ansReady && ansTpin);
	cov_full: cover property (bufFull);
	cov_stall: cover property ((ansValid && !ansReady) [*2]);
endmodule

bind cbs_event_slave cbs_event_slave_props props (
	.core_clk(core_clk), .reset_n(reset_n), .masterReset(masterReset), .geoAddress(geoAddress),
	.addrCycle(addrCycle), .addrKind(addrKind), .addrCsrSpace(addrCsrSpace), .addrValue(addrValue),
	.waitOut(waitOut), .dataSelected(dataSelected), .ansValid(ansValid), .ansReady(ansReady),
	.ansData(ansData), .ansTpin(ansTpin), .cfgWrite(cfgWrite), .loadNextEvent(loadNextEvent),
	.eventDone(eventDone), .bufferPointerReg(bufferPointerReg), .wordCountReg(wordCountReg),
	.memTestMode(memTestMode), .bufferingInProgress(bufferingInProgress), .bufFull(bufFull),
	.bufEmpty(bufEmpty)
);

// ### bench/tb_cbs_event_slave.sv
`timescale 1ns/1ps
`include "cbs_defs.vh"
module tb_cbs_event_slave;
	// Inputs driven by the bench.
	logic core_clk = 0, reset_n = 0, masterReset = 0, cfgWrite = 0, loadNextEvent = 0, feWrite = 0, fePhase = 1;
	logic eventDone = 0, eventPhase = 1, feBusy = 0, auxCardFlag = 0;
	logic [4:0] geoAddress = 5'h0B;
	logic [2:0] cfgSel = 3'h0;
	logic [31:0] cfgData = 32'h0;
	logic [10:0] feOffset = 11'h001, eventWords = 11'h000;
	logic [15:0] feTime = 16'h1234;
	logic [6:0] feChannel = 7'h05;
	// Bus side and outputs.
	wire addrCycle, addrCsrSpace, addrRelease, waitOut, dataSelected, csrSelected, dcRead, dcWrite, dcBlock, dcReady;
	wire ansValid, ansReady, ansTpin, memTestMode, bufferingInProgress, bufEmpty, bufFull;
	wire [1:0] addrKind;
	wire [2:0] ansStatus;
	wire [10:0] dcSecAddr;
	wire [31:0] addrValue, dcWriteData, ansData, logicalAddressReg, classEnableReg, bufferPointerReg, wordCountReg;
	logic [31:0] d;
	logic t;
	logic [2:0] s;
	int errors = 0, numChecks = 0;
	always #12.5 core_clk = ~core_clk;
	cbs_event_slave dut (
		.core_clk(core_clk), .reset_n(reset_n), .masterReset(masterReset), .geoAddress(geoAddress),
		.addrCycle(addrCycle), .addrKind(addrKind), .addrCsrSpace(addrCsrSpace), .addrValue(addrValue),
		.addrRelease(addrRelease), .waitOut(waitOut), .dataSelected(dataSelected), .csrSelected(csrSelected),
		.dcRead(dcRead), .dcWrite(dcWrite), .dcBlock(dcBlock), .dcSecAddr(dcSecAddr), .dcWriteData(dcWriteData),
		.dcReady(dcReady), .ansValid(ansValid), .ansReady(ansReady), .ansData(ansData), .ansTpin(ansTpin),
		.ansStatus(ansStatus), .cfgWrite(cfgWrite), .cfgSel(cfgSel), .cfgData(cfgData),
		.loadNextEvent(loadNextEvent), .logicalAddressReg(logicalAddressReg), .classEnableReg(classEnableReg),
		.bufferPointerReg(bufferPointerReg), .wordCountReg(wordCountReg), .memTestMode(memTestMode),
		.feWrite(feWrite), .feOffset(feOffset), .feTime(feTime), .fePhase(fePhase), .feChannel(feChannel),
		.eventDone(eventDone), .eventWords(eventWords), .eventPhase(eventPhase), .feBusy(feBusy),
		.auxCardFlag(auxCardFlag), .bufferingInProgress(bufferingInProgress), .bufEmpty(bufEmpty),
		.bufFull(bufFull)
	);
	cbs_bus_master master (
		.core_clk(core_clk), .addrCycle(addrCycle), .addrKind(addrKind), .addrCsrSpace(addrCsrSpace),
		.addrValue(addrValue), .addrRelease(addrRelease), .waitOut(waitOut), .dcRead(dcRead), .dcWrite(dcWrite),
		.dcBlock(dcBlock), .dcSecAddr(dcSecAddr), .dcWriteData(dcWriteData), .dcReady(dcReady),
		.ansValid(ansValid), .ansReady(ansReady), .ansData(ansData), .ansTpin(ansTpin), .ansStatus(ansStatus)
	);
	task automatic chk(input string n, input [31:0] e, input [31:0] g);
		numChecks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cfg(input [2:0] sel, input [31:0] v);
		@(negedge core_clk);
		cfgSel = sel;
		cfgData = v;
		cfgWrite = 1;
		@(negedge core_clk);
		cfgWrite = 0;
	endtask
	// Captures one event, optionally with one data word at offset 1.
	task automatic ev(input bit withWord);
		@(negedge core_clk);
		feWrite = withWord;
		@(negedge core_clk);
		feWrite = 0;
		eventWords = {10'h0, withWord};
		eventDone = 1;
		@(negedge core_clk);
		eventDone = 0;
	endtask
	// Master reset when mr is set, otherwise the advance-event command.
	task automatic cmd(input bit mr);
		@(negedge core_clk);
		masterReset = mr;
		loadNextEvent = !mr;
		@(negedge core_clk);
		masterReset = 0;
		loadNextEvent = 0;
	endtask
	task automatic scan(input [7:0] code, input bit e);
		master.addr(`CBS_KIND_BCAST, 0, {24'h0, code});
		master.rd(0, 11'h000, d, t, s);
		chk($sformatf("tpin %h", code), {31'h0, e}, {31'h0, t});
	endtask
	// Sets bit 26 so that the word holds an even number of ones.
	function automatic [31:0] even(input [31:0] w);
		even = w | {5'h0, ^w, 26'h0};
	endfunction
	task automatic testDone;
		if (errors == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#500000;
		errors++;
		testDone;
	end
	initial begin
		repeat (5) @(negedge core_clk);
		reset_n = 1;
		chk("pointers", 32'h700, bufferPointerReg);
		chk("empty", 32'h1, {31'h0, bufEmpty});
		chk("test mode", 32'h0, {31'h0, memTestMode});
		chk("idle buffering", 32'h0, {31'h0, bufferingInProgress});
		feBusy = 1;
		@(negedge core_clk);
		chk("busy buffering", 32'h1, {31'h0, bufferingInProgress});
		feBusy = 0;
		cfg(`CBS_SEL_LOGICAL, 32'hABCD0000);
		chk("logical reg", 32'hABCD0000, logicalAddressReg);
		master.addr(`CBS_KIND_GEO, 0, 32'h0B);
		chk("geo", 32'h1, {31'h0, dataSelected});
		master.addr(`CBS_KIND_LOGICAL, 1, 32'hABCD0000);
		chk("logical", 32'h1, {31'h0, csrSelected});
		master.addr(`CBS_KIND_LOGICAL, 0, 32'hABCE0000);
		chk("logical miss", 32'h0, {31'h0, dataSelected});
		cfg(`CBS_SEL_CLASS, 32'h4);
		chk("class reg", 32'h4, classEnableReg);
		master.addr(`CBS_KIND_BCAST, 0, 32'h25);
		chk("class on", 32'h1, {31'h0, dataSelected});
		master.addr(`CBS_KIND_BCAST, 0, 32'h15);
		chk("class off", 32'h0, {31'h0, dataSelected});
		master.addr(`CBS_KIND_BCAST, 0, 32'h01);
		chk("general", 32'h1, {31'h0, dataSelected});
		master.rd(0, 11'h003, d, t, s);
		chk("unmapped", `CBS_SS_NOADDR, {29'h0, s});
		scan(8'h09, 0);
		scan(8'h0D, 1);
		scan(8'h19, 1);
		scan(8'hBD, 0);
		auxCardFlag = 1;
		scan(8'hBD, 1);
		ev(1);
		chk("write advance", 32'h701, bufferPointerReg);
		scan(8'h09, 1);
		scan(8'hCD, 1);
		cmd(0);
		chk("read advance", 32'h001, bufferPointerReg);
		master.addr(`CBS_KIND_GEO, 0, 32'h0B);
		master.wr(11'h001, 32'h0BAD0BAD);
		master.issue(1, 11'h000);
		master.issue(1, 11'h000);
		repeat (3) @(negedge core_clk);
		chk("stall refuse", 32'h0, {31'h0, dcReady});
		master.take(d, t, s);
		chk("header", even({5'h0B, 10'h0, 1'b1, 5'h0, 11'h002}), d);
		master.take(d, t, s);
		chk("data word", even({5'h0B, 3'h0, 7'h05, 1'b1, 16'h1234}), d);
		master.rd(1, 11'h000, d, t, s);
		chk("block end", `CBS_SS_END, {29'h0, s});
		cfg(`CBS_SEL_TESTMODE, 32'h1);
		master.wr(11'h005, 32'hCAFE0001);
		master.rd(0, 11'h005, d, t, s);
		chk("test memory", 32'hCAFE0001, d);
		cfg(`CBS_SEL_WORDCOUNT, 32'h123);
		chk("word count", 32'h123, wordCountReg);
		cfg(`CBS_SEL_TESTMODE, 32'h0);
		repeat (6) ev(0);
		chk("full", 32'h1, {31'h0, bufFull});
		chk("buffering", 32'h1, {31'h0, bufferingInProgress});
		ev(0);
		chk("full holds", 32'h007, bufferPointerReg);
		master.drop();
		chk("release", 32'h0, {31'h0, dataSelected});
		cfg(`CBS_SEL_BUFPTR, 32'h00000305);
		chk("pointer write", 32'h305, bufferPointerReg);
		cmd(1);
		chk("master reset", 32'h700, bufferPointerReg);
		testDone;
	end
endmodule

// ### hw/cbs_defs.vh
`ifndef CBS_DEFS_VH
`define CBS_DEFS_VH

// Address cycle kinds.
`define CBS_KIND_GEO 2'h0
`define CBS_KIND_LOGICAL 2'h1
`define CBS_KIND_BCAST 2'h2

// Broadcast primary address codes, compared on the low byte; the class code on the low nibble.
`define CBS_BC_GENERAL 8'h01
`define CBS_BC_CLASS_LOW 4'h5
`define CBS_BC_SCAN_DATA 8'h09
`define CBS_BC_SCAN_FREE 8'h19
`define CBS_BC_PRESENCE 8'h0D
`define CBS_BC_AUX 8'hBD
`define CBS_BC_SCAN_NEXT 8'hCD

// Configuration port selects.
`define CBS_SEL_LOGICAL 3'h0
`define CBS_SEL_CLASS 3'h1
`define CBS_SEL_BUFPTR 3'h2
`define CBS_SEL_WORDCOUNT 3'h3
`define CBS_SEL_TESTMODE 3'h4

// Reset values.
`define CBS_RST_READ_PTR 3'h7
`define CBS_RST_WRITE_PTR 3'h0
`define CBS_RST_WORDCOUNT 11'h000

// Field positions of the logical address and buffer pointer registers.
`define CBS_LOGICAL_HI 31
`define CBS_LOGICAL_LO 16
`define CBS_BP_READ_HI 10
`define CBS_BP_READ_LO 8
`define CBS_BP_WRITE_HI 2
`define CBS_BP_WRITE_LO 0

// Word field positions.
`define CBS_W_PHASE 16
`define CBS_W_CHAN_LO 17
`define CBS_W_BUF_LO 24
`define CBS_W_PARITY 26
`define CBS_W_GEO_LO 27
`define CBS_H_BUF_LO 17

// Slave status codes.
`define CBS_SS_OK 3'h0
`define CBS_SS_END 3'h2
`define CBS_SS_NOADDR 3'h6

// Broadcast decode and handshake timing.
`define CBS_CLK_NS 25
`define CBS_HANDSHAKE_NS 500
`define CBS_HANDSHAKE_CYC (`CBS_HANDSHAKE_NS / `CBS_CLK_NS)
`define CBS_DECODE_CYC 1

`endif

// ### hw/cbs_event_slave.v
`timescale 1ns/1ps
`include "cbs_defs.vh"
module cbs_event_slave (
	// Clock and reset.
	input wire core_clk,
	input wire reset_n,
	input wire masterReset,
	// Slot identity.
	input wire [4:0] geoAddress,
	// Address cycle.
	input wire addrCycle,
	input wire [1:0] addrKind,
	input wire addrCsrSpace,
	input wire [31:0] addrValue,
	input wire addrRelease,
	output wire waitOut,
	output wire dataSelected,
	output wire csrSelected,
	// Data cycle in data space.
	input wire dcRead,
	input wire dcWrite,
	input wire dcBlock,
	input wire [10:0] dcSecAddr,
	input wire [31:0] dcWriteData,
	output wire dcReady,
	// Read answer.
	output wire ansValid,
	input wire ansReady,
	output wire [31:0] ansData,
	output wire ansTpin,
	output wire [2:0] ansStatus,
	// Configuration writes and read-back.
	input wire cfgWrite,
	input wire [2:0] cfgSel,
	input wire [31:0] cfgData,
	input wire loadNextEvent,
	output wire [31:0] logicalAddressReg,
	output wire [31:0] classEnableReg,
	output wire [31:0] bufferPointerReg,
	output wire [31:0] wordCountReg,
	output wire memTestMode,
	// Front-end event capture.
	input wire feWrite,
	input wire [10:0] feOffset,
	input wire [15:0] feTime,
	input wire fePhase,
	input wire [6:0] feChannel,
	input wire eventDone,
	input wire [10:0] eventWords,
	input wire eventPhase,
	input wire feBusy,
	input wire auxCardFlag,
	output wire bufferingInProgress,
	output wire bufEmpty,
	output wire bufFull
);
	localparam ST_IDLE = 3'b001;
	localparam ST_SEL = 3'b010;
	localparam ST_SCAN = 3'b100;

	reg [31:0] eventMem [0:16383];
	reg [10:0] bufWords [0:7];
	reg [2:0] state;
	reg [2:0] next_state;
	reg selCsr;
	reg next_selCsr;
	reg [7:0] scanCode;
	reg [15:0] logicalAddr;
	reg [3:0] classEnable;
	reg testMode;
	reg [2:0] readPtr;
	reg [2:0] writePtr;
	reg [10:0] wordCount;
	reg [10:0] rdOffset;
	reg pending;
	reg [31:0] memQ;
	reg pendTpin;
	reg [2:0] pendStatus;
	reg pendFromMem;
	reg next_tpin;
	reg [2:0] next_status;
	reg next_fromMem;
	reg [31:0] dataWord;
	reg [31:0] headerWord;
	reg [13:0] memWrAddr;
	reg [31:0] memWrData;
	reg memWrEn;
	wire [2:0] nextReadPtr;
	wire bcast;
	wire [7:0] bcLow;
	wire addrMatch;
	wire classHit;
	wire takeRead;
	wire takeWrite;
	wire inReady;
	wire [13:0] memRdAddr;
	wire [35:0] bufIn;
	wire [35:0] bufOut;
	wire nextHasData;
	wire inSel;

	assign nextReadPtr = readPtr + 3'h1;
	assign bcast = (addrKind == `CBS_KIND_BCAST);
	assign bcLow = addrValue[7:0];

	// Geographic and logical matches select whichever space the cycle names.
	assign addrMatch = (addrKind == `CBS_KIND_GEO && addrValue[4:0] == geoAddress) ||
		(addrKind == `CBS_KIND_LOGICAL && addrValue[`CBS_LOGICAL_HI:`CBS_LOGICAL_LO] == logicalAddr);

	// Class broadcast hits only on an enabled class below four.
	assign classHit = (bcLow[3:0] == `CBS_BC_CLASS_LOW) && (addrValue[31:8] == 24'h000000) &&
		(bcLow[7:6] == 2'h0) && classEnable[bcLow[5:4]];

	// WAIT is raised only while a broadcast address cycle is present; decode registers at the edge that ends that cycle.
	assign waitOut = addrCycle & bcast;

	// Buffer ring state.
	assign bufEmpty = (readPtr == writePtr - 3'h1);
	assign bufFull = (writePtr == readPtr - 3'h1);
	assign bufferingInProgress = feBusy | bufFull;
	assign nextHasData = ~bufEmpty && (bufWords[nextReadPtr] > 11'h001);

	// Selection state machine.
	always @* begin
		next_state = state;
		next_selCsr = selCsr;
		if (addrCycle) begin
			next_state = ST_IDLE;
			if (addrMatch) begin
				next_state = ST_SEL;
				next_selCsr = addrCsrSpace;
			end else if (bcast && addrValue == 32'h00000001) begin
				next_state = ST_SEL;
				next_selCsr = addrCsrSpace;
			end else if (bcast && classHit) begin
				next_state = ST_SEL;
				next_selCsr = addrCsrSpace;
			end else if (bcast && addrValue[31:8] == 24'h000000 && (bcLow == `CBS_BC_SCAN_DATA ||
				bcLow == `CBS_BC_SCAN_FREE || bcLow == `CBS_BC_PRESENCE || bcLow == `CBS_BC_AUX ||
				bcLow == `CBS_BC_SCAN_NEXT)) begin
				next_state = ST_SCAN;
				next_selCsr = 1'b0;
			end
		end else if (addrRelease) begin
			next_state = ST_IDLE;
		end
	end

	// State register and scan code capture.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			selCsr <= 1'b0;
			scanCode <= 8'h00;
		end else begin
			state <= next_state;
			selCsr <= next_selCsr;
			if (addrCycle) begin
				scanCode <= bcLow;
			end
		end
	end

	assign inSel = (state == ST_SEL);
	assign dataSelected = inSel & ~selCsr;
	assign csrSelected = inSel & selCsr;

	// Reads are taken one at a time while the answer buffer has room.
	assign dcReady = inReady & ~pending;
	assign takeRead = dcRead & dcReady & (dataSelected | (state == ST_SCAN));
	assign takeWrite = dcWrite & dataSelected & testMode;

	// Outside test mode only the first data port exists and steps through the buffer.
	assign memRdAddr = testMode ? {readPtr, dcSecAddr} : {readPtr, rdOffset};

	// Answer content of a read, chosen by mode.
	always @* begin
		next_tpin = 1'b0;
		next_status = `CBS_SS_OK;
		next_fromMem = 1'b0;
		case (state)
			ST_SCAN: begin
				case (scanCode)
					`CBS_BC_SCAN_DATA: next_tpin = ~bufEmpty;
					`CBS_BC_SCAN_FREE: next_tpin = bufEmpty | ~bufFull;
					`CBS_BC_PRESENCE: next_tpin = 1'b1;
					`CBS_BC_AUX: next_tpin = auxCardFlag;
					`CBS_BC_SCAN_NEXT: next_tpin = nextHasData;
					default: next_tpin = 1'b0;
				endcase
			end
			ST_SEL: begin
				if (dcBlock && wordCount == 11'h000) begin
					next_status = `CBS_SS_END;
				end else if (!testMode && dcSecAddr != 11'h000) begin
					next_status = `CBS_SS_NOADDR;
				end else begin
					next_fromMem = 1'b1;
				end
			end
			default: next_fromMem = 1'b0;
		endcase
	end

	// Front-end data word formatting with even parity.
	always @* begin
		dataWord = 32'h00000000;
		dataWord[15:0] = feTime;
		dataWord[`CBS_W_PHASE] = fePhase;
		dataWord[`CBS_W_CHAN_LO+6:`CBS_W_CHAN_LO] = feChannel;
		dataWord[`CBS_W_BUF_LO+1:`CBS_W_BUF_LO] = writePtr[1:0];
		dataWord[`CBS_W_GEO_LO+4:`CBS_W_GEO_LO] = geoAddress;
		dataWord[`CBS_W_PARITY] = ^dataWord;
	end

	// Header word: count includes the header itself.
	always @* begin
		headerWord = 32'h00000000;
		headerWord[10:0] = eventWords + 11'h001;
		headerWord[`CBS_W_PHASE] = eventPhase;
		headerWord[`CBS_H_BUF_LO+2:`CBS_H_BUF_LO] = writePtr;
		headerWord[`CBS_W_GEO_LO+4:`CBS_W_GEO_LO] = geoAddress;
		headerWord[`CBS_W_PARITY] = ^headerWord;
	end

	// One memory write port: header first, then front-end data, then test writes.
	always @* begin
		memWrEn = 1'b0;
		memWrAddr = {readPtr, dcSecAddr};
		memWrData = dcWriteData;
		if (eventDone && !bufFull) begin
			memWrEn = 1'b1;
			memWrAddr = {writePtr, 11'h000};
			memWrData = headerWord;
		end else if (feWrite && !bufFull) begin
			memWrEn = 1'b1;
			memWrAddr = {writePtr, feOffset};
			memWrData = dataWord;
		end else if (takeWrite) begin
			memWrEn = 1'b1;
		end
	end

	// Event memory and per-buffer word counts.
	always @(posedge core_clk) begin
		if (memWrEn) begin
			eventMem[memWrAddr] <= memWrData;
		end
		if (eventDone && !bufFull) begin
			bufWords[writePtr] <= eventWords + 11'h001;
		end
		if (takeRead) begin
			memQ <= eventMem[memRdAddr];
		end
	end

	// Pointer, word count and configuration registers.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			logicalAddr <= 16'h0000;
			classEnable <= 4'h0;
			testMode <= 1'b0;
			readPtr <= `CBS_RST_READ_PTR;
			writePtr <= `CBS_RST_WRITE_PTR;
			wordCount <= `CBS_RST_WORDCOUNT;
			rdOffset <= 11'h000;
		end else if (masterReset) begin
			readPtr <= `CBS_RST_READ_PTR;
			writePtr <= `CBS_RST_WRITE_PTR;
			wordCount <= `CBS_RST_WORDCOUNT;
			rdOffset <= 11'h000;
		end else begin
			if (eventDone && !bufFull) begin
				writePtr <= writePtr + 3'h1;
			end
			if (loadNextEvent) begin
				readPtr <= nextReadPtr;
				wordCount <= bufWords[nextReadPtr];
				rdOffset <= 11'h000;
			end else if (takeRead && next_fromMem) begin
				if (dcBlock) begin
					wordCount <= wordCount - 11'h001;
				end
				if (!testMode && rdOffset != 11'h7FF) begin
					rdOffset <= rdOffset + 11'h001;
				end
			end
			if (cfgWrite) begin
				case (cfgSel)
					`CBS_SEL_LOGICAL: logicalAddr <= cfgData[`CBS_LOGICAL_HI:`CBS_LOGICAL_LO];
					`CBS_SEL_CLASS: classEnable <= cfgData[3:0];
					`CBS_SEL_BUFPTR: begin
						readPtr <= cfgData[`CBS_BP_READ_HI:`CBS_BP_READ_LO];
						writePtr <= cfgData[`CBS_BP_WRITE_HI:`CBS_BP_WRITE_LO];
						rdOffset <= 11'h000;
					end
					`CBS_SEL_WORDCOUNT: begin
						if (testMode) begin
							wordCount <= cfgData[10:0];
						end
					end
					`CBS_SEL_TESTMODE: testMode <= cfgData[0];
					default: testMode <= testMode;
				endcase
			end
		end
	end

	// Read answer held one cycle behind the memory read.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			pending <= 1'b0;
			pendTpin <= 1'b0;
			pendStatus <= `CBS_SS_OK;
			pendFromMem <= 1'b0;
		end else begin
			pending <= takeRead;
			if (takeRead) begin
				pendTpin <= next_tpin;
				pendStatus <= next_status;
				pendFromMem <= next_fromMem;
			end
		end
	end

	assign bufIn = {pendStatus, pendTpin, pendFromMem ? memQ : 32'h00000000};

	// Two-entry answer buffer so a stalled receiver loses no word.
	cbs_two_entry_buffer #(
		.WIDTH(36)
	) answerBuffer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.inValid(pending),
		.inReady(inReady),
		.inData(bufIn),
		.outValid(ansValid),
		.outReady(ansReady),
		.outData(bufOut)
	);

	assign ansData = bufOut[31:0];
	assign ansTpin = bufOut[32];
	assign ansStatus = bufOut[35:33];

	// Register read-back; word count reads zero outside test mode.
	assign logicalAddressReg = {logicalAddr, 16'h0000};
	assign classEnableReg = {28'h0000000, classEnable};
	assign bufferPointerReg = {21'h000000, readPtr, 5'h00, writePtr};
	assign wordCountReg = testMode ? {21'h000000, wordCount} : 32'h00000000;
	assign memTestMode = testMode;
endmodule

// ### hw/cbs_two_entry_buffer.v
`timescale 1ns/1ps
module cbs_two_entry_buffer #(
	parameter WIDTH = 36
) (
	// Clock and reset.
	input wire core_clk,
	input wire reset_n,
	// Filling side.
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	// Draining side.
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] slot0;
	reg [WIDTH-1:0] slot1;
	reg [1:0] count;
	wire push;
	wire pop;

	// Slot 0 is always the head; full and empty come from the count.
	assign inReady = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign outData = slot0;
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	// Shift on pop, fill the first free slot on push.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			count <= 2'h0;
			slot0 <= {WIDTH{1'b0}};
			slot1 <= {WIDTH{1'b0}};
		end else begin
			if (pop) begin
				slot0 <= slot1;
			end
			if (push) begin
				if (count == 2'h0 || (count == 2'h1 && pop)) begin
					slot0 <= inData;
				end else begin
					slot1 <= inData;
				end
			end
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
